// file: hdl/wtm_defs.svh
// Purpose: widths, depths and reset values of the waveform trigger and marker controller
// Assumes: one sample clock, synchronous reset
// Notes: definitions only
`ifndef WTM_DEFS_SVH
`define WTM_DEFS_SVH

`define WTM_IQ_W 16
`define WTM_MKR_N 4
`define WTM_ADDR_W 8
`define WTM_DEPTH 256
`define WTM_SEG_N 4
`define WTM_SEG_W 2
`define WTM_DLY_W 16
`define WTM_PIN_N 3
`define WTM_PIN_KEY 0
`define WTM_PIN_EXT1 1
`define WTM_PIN_EXT2 2
`define WTM_RST_SEG_START 8'h00
`define WTM_RST_SEG_LAST 8'hff
`define WTM_RST_SEG_MKR_EN 4'hf

`endif

// file: hdl/wtm_pkg.sv
// Purpose: types shared by the waveform trigger and marker controller
// Assumes: wtm_defs.svh gives the widths
// Notes: enums carry no codes
`default_nettype none
`include "wtm_defs.svh"

package wtm_pkg;

  typedef enum logic [1:0] {TM_SINGLE, TM_GATED, TM_SEGADV, TM_CONT} wtm_mode_type;
  typedef enum logic [1:0] {SRC_KEY, SRC_BUS, SRC_EXT} wtm_src_type;
  typedef enum logic [1:0] {RT_OFF, RT_ON, RT_IMMED} wtm_retrig_type;
  typedef enum logic [1:0] {CR_FREE, CR_TRIG_RUN, CR_RESET_RUN} wtm_cont_type;
  typedef enum logic {SA_SINGLE, SA_CONT} wtm_segadv_type;
  typedef enum logic [1:0] {DK_STORED, DK_UNFRAMED, DK_FRAMED} wtm_kind_type;
  typedef enum logic [1:0] {ST_IDLE, ST_PLAY, ST_WAIT, ST_DONE} wtm_state_type;

  typedef struct packed {
    wtm_mode_type mode;
    wtm_src_type src;
    wtm_retrig_type retrig;
    wtm_cont_type cont;
    wtm_segadv_type segadv;
    wtm_kind_type kind;
    logic ext_pin2;
    logic ext_pol_pos;
    logic gate_high;
    logic dly_en;
  } wtm_trig_cfg_type;

  typedef struct packed {
    logic [`WTM_MKR_N-1:0] pol_neg;
    logic blank_en;
    logic [1:0] blank_sel;
  } wtm_mkr_cfg_type;

  typedef struct packed {
    logic [`WTM_IQ_W-1:0] i;
    logic [`WTM_IQ_W-1:0] q;
    logic [`WTM_MKR_N-1:0] mkr;
  } wtm_sample_type;

endpackage : wtm_pkg

`default_nettype wire

// file: hdl/wtm_mem.sv
// Purpose: sample memory, one write port and one registered read port
// Assumes: read data appear one cycle after the address
// Notes: contents are not cleared by reset
`default_nettype none
`include "wtm_defs.svh"

module wtm_mem (
  input wire logic clk_i,
  input wire logic we_i,
  input wire logic [`WTM_ADDR_W-1:0] waddr_i,
  input wire wtm_pkg::wtm_sample_type wdata_i,
  input wire logic [`WTM_ADDR_W-1:0] raddr_i,
  output wtm_pkg::wtm_sample_type rdata_o
);

  wtm_pkg::wtm_sample_type mem [`WTM_DEPTH];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end

endmodule : wtm_mem

`default_nettype wire

// file: hdl/wtm_ctrl.sv
// Purpose: trigger sourcing, playback sequencing and marker outputs of a waveform player
// Assumes: memory and segment table are loaded while playback is off
// Notes: a trigger reaches the first sample output three cycles after its event
//
// Function
// - event output active only for markers enabled in the playing segment
// - marker without points leaves its event output unchanged when enabled
// - each set and enabled marker pulses the event output of its number
// - blanking marker low suppresses output and holds level loop
// - per-marker polarity, negative inverts the marker signal
// - surplus trigger events while only one is needed are discarded
// - I and Q zero after mode select until first trigger, then persist
// - trigger source is key, host bus command or one of two external pins
// - trigger polarity picks the responding state, external source only
// - optional switchable delay between external trigger and response
// - four trigger modes, each with its own responses
// - single, retrigger off: play once, ignore during play, restart after
// - single, retrigger on: trigger during play queues one more play
// - single, immediate: trigger during play restarts from the beginning
// - gated waits for first active gate, then follows the gate input
// - active gate level selectable low or high
// - stored waveform gated: advance while inactive, freeze while active
// - unframed real-time gated: send while active, resume with next symbol
// - framed gated: start on frame boundary, stop at frame end if inactive
// - continuous: free run, trigger and run, reset and run
// - segment advance: finish segment, then next; last returns to first
`default_nettype none
`include "wtm_defs.svh"

module wtm_ctrl (
  input wire logic REF_CLK_I,
  input wire logic SRST_I,
  input wire logic ARB_ON_I,
  input wire wtm_pkg::wtm_trig_cfg_type TRIG_CFG_I,
  input wire wtm_pkg::wtm_mkr_cfg_type MKR_CFG_I,
  input wire logic [`WTM_DLY_W-1:0] EXT_DELAY_CYC_I,
  input wire logic KEY_I,
  input wire logic BUS_TRIG_I,
  input wire logic EXT_TRIG1_I,
  input wire logic EXT_TRIG2_I,
  input wire logic MEM_WE_I,
  input wire logic [`WTM_ADDR_W-1:0] MEM_WADDR_I,
  input wire wtm_pkg::wtm_sample_type MEM_WDATA_I,
  input wire logic SEG_WE_I,
  input wire logic [`WTM_SEG_W-1:0] SEG_IDX_I,
  input wire logic [`WTM_ADDR_W-1:0] SEG_START_I,
  input wire logic [`WTM_ADDR_W-1:0] SEG_LAST_I,
  input wire logic [`WTM_MKR_N-1:0] SEG_MKR_EN_I,
  input wire logic [`WTM_SEG_W-1:0] SEG_LAST_IDX_I,
  output wtm_pkg::wtm_sample_type SAMPLE_O,
  output logic SAMPLE_VALID_O,
  output logic [`WTM_MKR_N-1:0] EVENT_O,
  output logic OUTPUT_SUPPRESS_ROUTE_O,
  output logic LEVEL_LOOP_HOLD_O,
  output logic PLAYING_O,
  output logic [`WTM_SEG_W-1:0] SEG_O
);

  function automatic logic [`WTM_SEG_W-1:0] seg_after(input logic [`WTM_SEG_W-1:0] s,
                                                     input logic [`WTM_SEG_W-1:0] last);
    seg_after = (s == last) ? '0 : s + 1'b1;
  endfunction : seg_after

  // input synchronisers, stage one only feeds stage two
  logic [`WTM_PIN_N-1:0] sync1;
  logic [`WTM_PIN_N-1:0] sync2;

  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= {EXT_TRIG2_I, EXT_TRIG1_I, KEY_I};
      sync2 <= sync1;
    end
  end

  // trigger path
  logic ext_prev, next_ext_prev;
  logic key_prev, next_key_prev;
  logic dly_busy, next_dly_busy;
  logic [`WTM_DLY_W-1:0] dly_cnt, next_dly_cnt;
  logic ext_lvl, ext_act, ext_evt, gate_act, trig_evt;

  always_comb begin
    ext_lvl = TRIG_CFG_I.ext_pin2 ? sync2[`WTM_PIN_EXT2] : sync2[`WTM_PIN_EXT1];
    ext_act = ext_lvl ~^ TRIG_CFG_I.ext_pol_pos;
    gate_act = ext_lvl ~^ TRIG_CFG_I.gate_high;
    next_ext_prev = ext_act;
    next_key_prev = sync2[`WTM_PIN_KEY];
    next_dly_busy = dly_busy;
    next_dly_cnt = dly_cnt;
    ext_evt = 1'b0;
    if (!TRIG_CFG_I.dly_en) begin
      ext_evt = ext_act & ~ext_prev;
      next_dly_busy = 1'b0;
    end else if (dly_busy) begin
      // edges while the delay runs are dropped, one pending trigger only
      if (dly_cnt == '0) begin
        ext_evt = 1'b1;
        next_dly_busy = 1'b0;
      end else begin
        next_dly_cnt = dly_cnt - 1'b1;
      end
    end else if (ext_act & ~ext_prev) begin
      next_dly_busy = 1'b1;
      next_dly_cnt = EXT_DELAY_CYC_I;
    end
    case (TRIG_CFG_I.src)
      wtm_pkg::SRC_KEY: trig_evt = sync2[`WTM_PIN_KEY] & ~key_prev;
      wtm_pkg::SRC_BUS: trig_evt = BUS_TRIG_I;
      wtm_pkg::SRC_EXT: trig_evt = ext_evt;
      default: trig_evt = 1'b0;
    endcase
  end

  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      // prev held active so an idle pin that already reads active makes no false edge
      ext_prev <= 1'b1;
      key_prev <= 1'b0;
      dly_busy <= 1'b0;
      dly_cnt <= '0;
    end else begin
      ext_prev <= next_ext_prev;
      key_prev <= next_key_prev;
      dly_busy <= next_dly_busy;
      dly_cnt <= next_dly_cnt;
    end
  end

  // segment table
  logic [`WTM_ADDR_W-1:0] seg_start [`WTM_SEG_N];
  logic [`WTM_ADDR_W-1:0] seg_last [`WTM_SEG_N];
  logic [`WTM_MKR_N-1:0] seg_mkr_en [`WTM_SEG_N];
  logic [`WTM_ADDR_W-1:0] next_seg_start [`WTM_SEG_N];
  logic [`WTM_ADDR_W-1:0] next_seg_last [`WTM_SEG_N];
  logic [`WTM_MKR_N-1:0] next_seg_mkr_en [`WTM_SEG_N];

  always_comb begin
    next_seg_start = seg_start;
    next_seg_last = seg_last;
    next_seg_mkr_en = seg_mkr_en;
    if (SEG_WE_I) begin
      next_seg_start[SEG_IDX_I] = SEG_START_I;
      next_seg_last[SEG_IDX_I] = SEG_LAST_I;
      next_seg_mkr_en[SEG_IDX_I] = SEG_MKR_EN_I;
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      for (int n = 0; n < `WTM_SEG_N; n++) begin
        seg_start[n] <= `WTM_RST_SEG_START;
        seg_last[n] <= `WTM_RST_SEG_LAST;
        seg_mkr_en[n] <= `WTM_RST_SEG_MKR_EN;
      end
    end else begin
      seg_start <= next_seg_start;
      seg_last <= next_seg_last;
      seg_mkr_en <= next_seg_mkr_en;
    end
  end

  // playback sequencer
  wtm_pkg::wtm_state_type state, next_state;
  wtm_pkg::wtm_trig_cfg_type cfg_prev;
  logic [`WTM_ADDR_W-1:0] ptr, next_ptr;
  logic [`WTM_SEG_W-1:0] seg, next_seg;
  logic pend, next_pend;
  logic frame_run, next_frame_run;
  logic adv, restart, cfg_chg, at_seg_end, at_seq_end, run_now;
  logic [`WTM_ADDR_W-1:0] step_ptr;
  logic [`WTM_SEG_W-1:0] step_seg;

  always_comb begin
    cfg_chg = (TRIG_CFG_I != cfg_prev) | ~ARB_ON_I;
    at_seg_end = ptr == seg_last[seg];
    at_seq_end = at_seg_end && (seg == SEG_LAST_IDX_I);
    step_seg = at_seg_end ? seg_after(seg, SEG_LAST_IDX_I) : seg;
    step_ptr = at_seg_end ? seg_start[step_seg] : ptr + 1'b1;
    next_state = state;
    next_ptr = ptr;
    next_seg = seg;
    next_pend = pend;
    next_frame_run = frame_run;
    adv = 1'b0;
    restart = 1'b0;
    run_now = 1'b0;
    case (state)
      wtm_pkg::ST_IDLE: begin
        case (TRIG_CFG_I.mode)
          wtm_pkg::TM_GATED: restart = gate_act;
          wtm_pkg::TM_CONT: restart = (TRIG_CFG_I.cont == wtm_pkg::CR_FREE) | trig_evt;
          default: restart = trig_evt;
        endcase
        if (restart) begin
          next_state = wtm_pkg::ST_PLAY;
        end
      end
      wtm_pkg::ST_PLAY: begin
        next_seg = step_seg;
        next_ptr = step_ptr;
        case (TRIG_CFG_I.mode)
          wtm_pkg::TM_SINGLE: begin
            adv = 1'b1;
            if (trig_evt && TRIG_CFG_I.retrig == wtm_pkg::RT_IMMED) begin
              restart = 1'b1;
            end else if (at_seq_end) begin
              if (pend | (trig_evt && TRIG_CFG_I.retrig == wtm_pkg::RT_ON)) begin
                restart = 1'b1;
              end else begin
                next_state = wtm_pkg::ST_DONE;
              end
              next_pend = 1'b0;
            end else if (trig_evt && TRIG_CFG_I.retrig == wtm_pkg::RT_ON) begin
              next_pend = 1'b1;
            end
          end
          wtm_pkg::TM_CONT: begin
            adv = 1'b1;
            restart = trig_evt && TRIG_CFG_I.cont == wtm_pkg::CR_RESET_RUN;
          end
          wtm_pkg::TM_SEGADV: begin
            adv = 1'b1;
            if (at_seg_end) begin
              next_pend = 1'b0;
              if (!(pend | trig_evt)) begin
                if (TRIG_CFG_I.segadv == wtm_pkg::SA_SINGLE) begin
                  next_state = wtm_pkg::ST_WAIT;
                  next_seg = seg;
                  next_ptr = seg_start[seg];
                end else begin
                  next_seg = seg;
                  next_ptr = seg_start[seg];
                end
              end
            end else if (trig_evt) begin
              next_pend = 1'b1;
            end
          end
          wtm_pkg::TM_GATED: begin
            case (TRIG_CFG_I.kind)
              wtm_pkg::DK_STORED: run_now = ~gate_act;
              wtm_pkg::DK_UNFRAMED: run_now = gate_act;
              default: begin
                run_now = frame_run | ((ptr == seg_start[seg]) & gate_act);
                next_frame_run = at_seg_end ? gate_act : run_now;
              end
            endcase
            adv = run_now;
            if (!run_now) begin
              // frozen: hold the position so play resumes on the next sample
              next_seg = seg;
              next_ptr = ptr;
            end
          end
          default: adv = 1'b0;
        endcase
      end
      wtm_pkg::ST_WAIT: begin
        if (trig_evt) begin
          next_state = wtm_pkg::ST_PLAY;
          next_seg = seg_after(seg, SEG_LAST_IDX_I);
          next_ptr = seg_start[seg_after(seg, SEG_LAST_IDX_I)];
        end
      end
      wtm_pkg::ST_DONE: begin
        restart = trig_evt;
        if (restart) begin
          next_state = wtm_pkg::ST_PLAY;
        end
      end
      default: next_state = wtm_pkg::ST_IDLE;
    endcase
    if (restart) begin
      next_seg = '0;
      next_ptr = seg_start[0];
      next_pend = 1'b0;
      next_frame_run = 1'b0;
    end
    if (cfg_chg) begin
      next_state = wtm_pkg::ST_IDLE;
      next_seg = '0;
      next_ptr = seg_start[0];
      next_pend = 1'b0;
      next_frame_run = 1'b0;
      adv = 1'b0;
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      state <= wtm_pkg::ST_IDLE;
      cfg_prev <= '0;
      ptr <= '0;
      seg <= '0;
      pend <= 1'b0;
      frame_run <= 1'b0;
    end else begin
      state <= next_state;
      cfg_prev <= TRIG_CFG_I;
      ptr <= next_ptr;
      seg <= next_seg;
      pend <= next_pend;
      frame_run <= next_frame_run;
    end
  end

  // sample memory, read data one cycle after the address
  wtm_pkg::wtm_sample_type rd_data;

  wtm_mem u_mem (
    .clk_i(REF_CLK_I),
    .we_i(MEM_WE_I),
    .waddr_i(MEM_WADDR_I),
    .wdata_i(MEM_WDATA_I),
    .raddr_i(ptr),
    .rdata_o(rd_data)
  );

  // output stage
  logic rd_valid, next_rd_valid;
  logic [`WTM_SEG_W-1:0] rd_seg, next_rd_seg;
  wtm_pkg::wtm_sample_type next_sample;
  logic [`WTM_MKR_N-1:0] next_event;
  logic next_blank;

  always_comb begin
    next_rd_valid = adv;
    next_rd_seg = seg;
    next_sample = SAMPLE_O;
    if (cfg_chg) begin
      next_sample = '0;
      next_rd_valid = 1'b0;
    end else if (rd_valid) begin
      next_sample = rd_data;
      // marker points without an enable, or no points at all, stay inactive
      next_sample.mkr = rd_data.mkr & seg_mkr_en[rd_seg];
    end else if (state != wtm_pkg::ST_PLAY) begin
      next_sample.mkr = '0;
    end
    next_event = next_sample.mkr ^ MKR_CFG_I.pol_neg;
    next_blank = MKR_CFG_I.blank_en & ~next_event[MKR_CFG_I.blank_sel];
  end

  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      rd_valid <= 1'b0;
      rd_seg <= '0;
      SAMPLE_O <= '0;
      SAMPLE_VALID_O <= 1'b0;
      EVENT_O <= '0;
      OUTPUT_SUPPRESS_ROUTE_O <= 1'b0;
      LEVEL_LOOP_HOLD_O <= 1'b0;
      PLAYING_O <= 1'b0;
      SEG_O <= '0;
    end else begin
      rd_valid <= next_rd_valid;
      rd_seg <= next_rd_seg;
      SAMPLE_O <= next_sample;
      SAMPLE_VALID_O <= rd_valid & ~cfg_chg;
      EVENT_O <= next_event;
      OUTPUT_SUPPRESS_ROUTE_O <= next_blank;
      LEVEL_LOOP_HOLD_O <= next_blank;
      PLAYING_O <= next_state == wtm_pkg::ST_PLAY;
      SEG_O <= next_seg;
    end
  end

endmodule : wtm_ctrl

`default_nettype wire

// file: tb/wtm_checker.sv
// Purpose: port-level assertions for the waveform trigger and marker controller
// Assumes: marker config held steady while watched
// Notes: bound to wtm_ctrl below
`default_nettype none
`include "wtm_defs.svh"

module wtm_checker (
  input wire logic REF_CLK_I,
  input wire logic SRST_I,
  input wire logic ARB_ON_I,
  input wire logic BUS_TRIG_I,
  input wire wtm_pkg::wtm_trig_cfg_type TRIG_CFG_I,
  input wire wtm_pkg::wtm_mkr_cfg_type MKR_CFG_I,
  input wire wtm_pkg::wtm_sample_type SAMPLE_O,
  input wire logic SAMPLE_VALID_O,
  input wire logic [`WTM_MKR_N-1:0] EVENT_O,
  input wire logic OUTPUT_SUPPRESS_ROUTE_O,
  input wire logic LEVEL_LOOP_HOLD_O,
  input wire logic PLAYING_O
);
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (SRST_I);

  a_suppress_blank: assert property (
    !$past(SRST_I) |-> OUTPUT_SUPPRESS_ROUTE_O ==
    (MKR_CFG_I.blank_en && !EVENT_O[MKR_CFG_I.blank_sel])) else $error("blanking wrong");
  a_hold_blank: assert property (
    LEVEL_LOOP_HOLD_O == OUTPUT_SUPPRESS_ROUTE_O) else $error("level hold wrong");
  a_event_pol: assert property (
    SAMPLE_VALID_O |-> EVENT_O == (SAMPLE_O.mkr ^ MKR_CFG_I.pol_neg)) else $error("event polarity");
  a_idle_iq_zero: assert property (
    (!ARB_ON_I) [*3] |=> SAMPLE_O.i == '0 && SAMPLE_O.q == '0 && !SAMPLE_VALID_O && !PLAYING_O)
    else $error("idle output not zero");
  a_idle_event: assert property (
    (!ARB_ON_I) [*3] |=> EVENT_O == MKR_CFG_I.pol_neg) else $error("idle event level");
  a_bus_start: assert property (
    !$past(SRST_I) && $stable(TRIG_CFG_I) && $past(ARB_ON_I) && ARB_ON_I && BUS_TRIG_I &&
    !PLAYING_O && TRIG_CFG_I.mode == wtm_pkg::TM_SINGLE && TRIG_CFG_I.src == wtm_pkg::SRC_BUS
    |=> PLAYING_O ##2 SAMPLE_VALID_O) else $error("bus trigger did not start play");
  a_no_self_start: assert property (
    !PLAYING_O && !BUS_TRIG_I && ARB_ON_I && TRIG_CFG_I.mode == wtm_pkg::TM_SINGLE &&
    TRIG_CFG_I.src == wtm_pkg::SRC_BUS && TRIG_CFG_I.retrig == wtm_pkg::RT_OFF
    |=> !PLAYING_O) else $error("play without trigger");
  a_play_valid: assert property (
    (PLAYING_O && ARB_ON_I && $stable(TRIG_CFG_I)) [*3] ##0
    (TRIG_CFG_I.mode == wtm_pkg::TM_SINGLE && TRIG_CFG_I.retrig == wtm_pkg::RT_OFF)
    |-> SAMPLE_VALID_O) else $error("gap in played samples");
endmodule : wtm_checker

bind wtm_ctrl wtm_checker u_chk (.REF_CLK_I, .SRST_I, .ARB_ON_I, .BUS_TRIG_I, .TRIG_CFG_I,
  .MKR_CFG_I, .SAMPLE_O, .SAMPLE_VALID_O, .EVENT_O, .OUTPUT_SUPPRESS_ROUTE_O,
  .LEVEL_LOOP_HOLD_O, .PLAYING_O);

`default_nettype wire

// file: tb/wtm_src.sv
// Purpose: external trigger and gate source on the two trigger pins
// Assumes: levels change on the sample clock edge
// Notes: pin 1 idles low, pin 2 idles high
`default_nettype none

module wtm_src (
  input wire logic clk_i,
  output logic ext1_o,
  output logic ext2_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    ext1_o = 1'b0;
    ext2_o = 1'b1;
  end
  // hold time in cycles so the device's two-stage sync sees a clean level
  task automatic drive(input logic pin2, input logic lvl, input int cycles);
    @(posedge clk_i);
    if (pin2) ext2_o <= lvl;
    else ext1_o <= lvl;
    repeat (cycles) @(posedge clk_i);
  endtask : drive
endmodule : wtm_src

`default_nettype wire

// file: tb/test_wtm_ctrl.sv
// Purpose: directed test of trigger modes, gating and marker outputs
// Assumes: two segments of four samples each
// Notes: marker config fixed, polarity inverts marker 1
`default_nettype none
`include "wtm_defs.svh"

module test_wtm_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic REF_CLK_I = 1'b0;
  logic SRST_I = 1'b1;
  logic ARB_ON_I = 1'b0;
  wtm_pkg::wtm_trig_cfg_type TRIG_CFG_I;
  wtm_pkg::wtm_mkr_cfg_type MKR_CFG_I = '{4'h2, 1'b1, 2'h0};
  logic [`WTM_DLY_W-1:0] EXT_DELAY_CYC_I = 16'h000a;
  logic KEY_I = 1'b0;
  logic BUS_TRIG_I = 1'b0;
  logic EXT_TRIG1_I, EXT_TRIG2_I, MEM_WE_I = 1'b0, SEG_WE_I = 1'b0;
  logic [`WTM_ADDR_W-1:0] MEM_WADDR_I = 8'h00, SEG_START_I = 8'h00, SEG_LAST_I = 8'h00;
  wtm_pkg::wtm_sample_type MEM_WDATA_I = '0, SAMPLE_O;
  logic [`WTM_SEG_W-1:0] SEG_IDX_I = 2'h0, SEG_LAST_IDX_I = 2'h1, SEG_O;
  logic [`WTM_MKR_N-1:0] SEG_MKR_EN_I = 4'h0, EVENT_O;
  logic SAMPLE_VALID_O, OUTPUT_SUPPRESS_ROUTE_O, LEVEL_LOOP_HOLD_O, PLAYING_O;
  int num_errors = 0;
  int comparisons = 0;
  int waited, ca, ci;
  wtm_pkg::wtm_trig_cfg_type rc;

  always #4 REF_CLK_I = ~REF_CLK_I;
  wtm_src src (.clk_i(REF_CLK_I), .ext1_o(EXT_TRIG1_I), .ext2_o(EXT_TRIG2_I));
  wtm_ctrl dut (.REF_CLK_I, .SRST_I, .ARB_ON_I, .TRIG_CFG_I, .MKR_CFG_I, .EXT_DELAY_CYC_I,
    .KEY_I, .BUS_TRIG_I, .EXT_TRIG1_I, .EXT_TRIG2_I, .MEM_WE_I, .MEM_WADDR_I, .MEM_WDATA_I,
    .SEG_WE_I, .SEG_IDX_I, .SEG_START_I, .SEG_LAST_I, .SEG_MKR_EN_I, .SEG_LAST_IDX_I,
    .SAMPLE_O, .SAMPLE_VALID_O, .EVENT_O, .OUTPUT_SUPPRESS_ROUTE_O, .LEVEL_LOOP_HOLD_O,
    .PLAYING_O, .SEG_O);

  // markers set only on the first sample of each segment
  function automatic logic [35:0] word(input int a);
    return {16'(a + 1), 16'(a + 160), (a % 4 == 0) ? 4'h5 : 4'h0};
  endfunction : word

  function automatic wtm_pkg::wtm_trig_cfg_type cfg(input wtm_pkg::wtm_mode_type m,
      input wtm_pkg::wtm_src_type s, input wtm_pkg::wtm_retrig_type r,
      input wtm_pkg::wtm_kind_type k, input logic [3:0] f);
    return '{m, s, r, wtm_pkg::CR_FREE, wtm_pkg::SA_SINGLE, k, f[3], f[2], f[1], f[0]};
  endfunction : cfg

  task automatic stop_test;
    if (num_errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test

  task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic tick;
    @(posedge REF_CLK_I);
    #1;
  endtask : tick

  // a config change idles the block, so let it settle before triggering
  task automatic set_cfg(input wtm_pkg::wtm_trig_cfg_type c);
    @(posedge REF_CLK_I) TRIG_CFG_I <= c;
    repeat (3) tick();
  endtask : set_cfg

  task automatic pulse_bus;
    @(posedge REF_CLK_I) BUS_TRIG_I <= 1'b1;
    @(posedge REF_CLK_I) BUS_TRIG_I <= 1'b0;
    #1;
  endtask : pulse_bus

  task automatic seek(input int a, input int lim);
    waited = 0;
    while (!(SAMPLE_VALID_O === 1'b1 && SAMPLE_O.i === 16'(a + 1)) && waited < lim) begin
      tick();
      waited++;
    end
    if (waited >= lim) begin
      chk("sample wait", 36'h1, 36'h0);
      stop_test();
    end
  endtask : seek

  task automatic play(input int first, input int n, input int trig_at);
    logic [35:0] w;
    seek(first, 60);
    for (int j = 0; j < n; j++) begin
      w = word(first + j);
      w[3:0] = w[3:0] & ((first + j < 4) ? 4'h1 : 4'he);
      chk("valid", 36'h1, {35'h0, SAMPLE_VALID_O});
      chk("sample", w, SAMPLE_O);
      chk("event", {32'h0, w[3:0] ^ 4'h2}, {32'h0, EVENT_O});
      @(posedge REF_CLK_I) BUS_TRIG_I <= (j == trig_at);
      #1;
    end
  endtask : play

  task automatic quiet(input string what, input int n);
    repeat (n) begin
      tick();
      chk(what, 36'h0, {35'h0, SAMPLE_VALID_O});
    end
  endtask : quiet

  task automatic count(input int n, output int c);
    c = 0;
    repeat (n) begin
      tick();
      c += (SAMPLE_VALID_O === 1'b1);
    end
  endtask : count

  initial begin
    TRIG_CFG_I = cfg(wtm_pkg::TM_SINGLE, wtm_pkg::SRC_BUS, wtm_pkg::RT_OFF,
      wtm_pkg::DK_STORED, 4'h0);
    repeat (2) @(posedge REF_CLK_I);
    SRST_I <= 1'b0;
    for (int a = 0; a < 8; a++) begin
      @(posedge REF_CLK_I) MEM_WE_I <= 1'b1;
      MEM_WADDR_I <= 8'(a);
      MEM_WDATA_I <= word(a);
      SEG_WE_I <= (a < 2);
      SEG_IDX_I <= 2'(a);
      SEG_START_I <= 8'(4 * a);
      SEG_LAST_I <= 8'(4 * a + 3);
      SEG_MKR_EN_I <= (a == 0) ? 4'h1 : 4'he;
    end
    @(posedge REF_CLK_I) MEM_WE_I <= 1'b0;
    SEG_WE_I <= 1'b0;
    ARB_ON_I <= 1'b1;
    repeat (3) tick();
    chk("i before trigger", 36'h0, {20'h0, SAMPLE_O.i});
    pulse_bus();
    play(0, 8, 3);
    quiet("single play", 12);
    chk("i persists", 36'h8, {20'h0, SAMPLE_O.i});
    set_cfg(cfg(wtm_pkg::TM_SINGLE, wtm_pkg::SRC_BUS, wtm_pkg::RT_ON, wtm_pkg::DK_STORED, 4'h0));
    chk("i after mode select", 36'h0, {20'h0, SAMPLE_O.i});
    pulse_bus();
    play(0, 8, 2);
    play(0, 8, -1);
    quiet("one more play", 10);
    set_cfg(cfg(wtm_pkg::TM_SINGLE, wtm_pkg::SRC_BUS, wtm_pkg::RT_IMMED,
      wtm_pkg::DK_STORED, 4'h0));
    pulse_bus();
    play(0, 3, 1);
    seek(0, 7);
    play(0, 8, -1);
    set_cfg(cfg(wtm_pkg::TM_SEGADV, wtm_pkg::SRC_BUS, wtm_pkg::RT_OFF, wtm_pkg::DK_STORED, 4'h0));
    pulse_bus();
    play(0, 4, -1);
    quiet("segment wait", 6);
    chk("segment", 36'h0, {34'h0, SEG_O});
    pulse_bus();
    play(4, 4, -1);
    pulse_bus();
    play(0, 4, -1);
    set_cfg(cfg(wtm_pkg::TM_SINGLE, wtm_pkg::SRC_KEY, wtm_pkg::RT_OFF, wtm_pkg::DK_STORED, 4'h0));
    @(posedge REF_CLK_I) KEY_I <= 1'b1;
    repeat (4) @(posedge REF_CLK_I);
    KEY_I <= 1'b0;
    play(0, 8, -1);
    // pin 2, respond to low, delay on
    set_cfg(cfg(wtm_pkg::TM_SINGLE, wtm_pkg::SRC_EXT, wtm_pkg::RT_OFF, wtm_pkg::DK_STORED, 4'h9));
    src.drive(1'b0, 1'b1, 6);
    src.drive(1'b0, 1'b0, 0);
    quiet("other pin", 20);
    src.drive(1'b1, 1'b0, 0);
    seek(0, 40);
    chk("delayed start", 36'h1, {35'h0, waited > 10 && waited < 24});
    play(0, 8, -1);
    src.drive(1'b1, 1'b1, 0);
    quiet("inactive edge", 30);
    for (int k = 0; k < 3; k++) begin
      set_cfg(cfg(wtm_pkg::TM_GATED, wtm_pkg::SRC_EXT, wtm_pkg::RT_OFF,
        (k == 2) ? wtm_pkg::DK_FRAMED : (k ? wtm_pkg::DK_UNFRAMED : wtm_pkg::DK_STORED), 4'h2));
      quiet("before first gate", 20);
      src.drive(1'b0, 1'b1, 8);
      count(8, ca);
      src.drive(1'b0, 1'b0, 8);
      count(8, ci);
      chk("gated", 36'h1, {35'h0, k ? (ci == 0 && ca > 3) : (ca == 0 && ci > 3)});
    end
    rc = cfg(wtm_pkg::TM_CONT, wtm_pkg::SRC_BUS, wtm_pkg::RT_OFF, wtm_pkg::DK_STORED, 4'h0);
    rc.cont = wtm_pkg::CR_TRIG_RUN;
    set_cfg(rc);
    quiet("trigger and run wait", 6);
    pulse_bus();
    play(0, 8, 3);
    rc.cont = wtm_pkg::CR_RESET_RUN;
    set_cfg(rc);
    pulse_bus();
    play(0, 3, 1);
    seek(0, 7);
    set_cfg(cfg(wtm_pkg::TM_CONT, wtm_pkg::SRC_BUS, wtm_pkg::RT_OFF, wtm_pkg::DK_STORED, 4'h0));
    play(0, 8, -1);
    @(posedge REF_CLK_I) ARB_ON_I <= 1'b0;
    repeat (4) tick();
    chk("i when off", 36'h0, {20'h0, SAMPLE_O.i});
    stop_test();
  end
endmodule : test_wtm_ctrl

`default_nettype wire
